// ==== hdl/lgam_mapper.sv ====
// The Avalon-MM interface to the registers was decided locally.
`timescale 1ns/10ps
module lgam_mapper #(
  parameter int unsigned RAM_SIZE = 32'h0000_3000,
  parameter int unsigned DF_SIZE = 32'h0000_8000,
  parameter int unsigned FLASH_SIZE = 32'h0004_0000
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // register bus, avalon-mm slave
  input wire logic [7:0] avsAddress,
  input wire logic avsRead,
  input wire logic avsWrite,
  input wire logic [31:0] avsWriteData,
  input wire logic [3:0] avsByteEnable,
  output logic [31:0] avsReadData,
  output logic avsWaitrequest,
  // processor core access
  input wire logic coreValid,
  input wire logic [15:0] coreAddr,
  input wire logic coreGlobal,
  input wire logic coreFirmware,
  input wire logic farPageLoad,
  input wire logic [7:0] farPageData,
  output logic [7:0] programWindowPage,
  output lgam_pkg::lgam_xlat_t coreXlat,
  output logic illegalAccessReset,
  // debug unit access
  input wire logic debugValid,
  input wire logic [15:0] debugAddr,
  input wire logic debugActive,
  input wire logic debugFirmwareRead,
  input wire logic debugFirmwareWrite,
  output lgam_pkg::lgam_xlat_t debugXlat,
  // operating mode
  input wire logic modeStrap,
  output logic debugInControl
);

  // ---------------------------------------------------------------
  // implemented space
  // ---------------------------------------------------------------
  // ram bottom
  localparam logic [22:0] RAM_LOW = 23'(lgam_pkg::GLB_RAM_TOP - RAM_SIZE);
  localparam logic [22:0] DF_HIGH = 23'(lgam_pkg::GLB_RAM_TOP + DF_SIZE);
  localparam logic [22:0] FLASH_LOW = 23'(32'h0080_0000 - FLASH_SIZE);

  logic [6:0] globalPage_r;
  logic [6:0] globalPage_nxt;
  logic [7:0] progPage_r;
  logic [7:0] progPage_nxt;
  logic [7:0] ramPage_r;
  logic [7:0] ramPage_nxt;
  logic [7:0] dfPage_r;
  logic [7:0] dfPage_nxt;
  logic wait_r;
  logic wait_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic modeSpecial_r;
  logic modeSpecial_nxt;
  logic strapTaken_r;
  logic strapTaken_nxt;
  logic [2:0] strapSync_r;
  logic [2:0] strapSync_nxt;
  logic strapLevel_r;
  logic strapLevel_nxt;
  logic inCtrl_r;
  logic inCtrl_nxt;
  lgam_pkg::lgam_xlat_t coreXlat_r;
  lgam_pkg::lgam_xlat_t coreXlat_nxt;
  lgam_pkg::lgam_xlat_t debugXlat_r;
  lgam_pkg::lgam_xlat_t debugXlat_nxt;
  logic illegal_r;
  logic illegal_nxt;
  logic fwCycle;
  logic busWr;
  logic [5:0] regIdx;

  // ---------------------------------------------------------------
  // address translation
  // ---------------------------------------------------------------
  // one function for both masters, so the debug unit sees the core scheme
  function automatic lgam_pkg::lgam_xlat_t xlatAccess(
    input logic v,
    input logic [15:0] a,
    input logic glob,
    input logic fw,
    input logic dbgOn,
    input logic [6:0] gp,
    input logic [7:0] pp,
    input logic [7:0] rp,
    input logic [7:0] ep
  );
    lgam_pkg::lgam_xlat_t x;
    logic [22:0] g;
    logic inDebug;
    logic unimpl;
    x = '0;
    g = 23'h00_0000;
    if (glob) begin
      g = {gp, a};
    end else if (a < lgam_pkg::LOC_DF_WIN) begin
      g = {7'h00, a};
    end else if (a < lgam_pkg::LOC_DF_FIXED) begin
      g = {3'b001, 2'b00, ep, a[9:0]};
    end else if (a < lgam_pkg::LOC_RAM_WIN) begin
      g = {3'b001, 2'b00, lgam_pkg::DF_FIXED_PAGE_HI, a[10], a[9:0]};
    end else if (a < lgam_pkg::LOC_RAM_FIXED) begin
      // ram window, page 0x00 below offset 0x800 falls on registers
      g = {3'b000, rp, a[11:0]};
    end else if (a < lgam_pkg::LOC_FLASH_FIXED_LO) begin
      g = {3'b000, lgam_pkg::RAM_FIXED_PAGE_HI, a[12], a[11:0]};
    end else if (a < lgam_pkg::LOC_PROG_WIN) begin
      g = {1'b1, lgam_pkg::FLASH_LOW_PAGE, a[13:0]};
    end else if (a < lgam_pkg::LOC_UNPAGED) begin
      g = {1'b1, pp, a[13:0]};
    end else begin
      g = {1'b1, lgam_pkg::FLASH_TOP_PAGE, a[13:0]};
    end
    // debug page top; also reached via program page 0xFF
    inDebug = dbgOn && !glob && (g[22:8] == lgam_pkg::GLB_DEBUG_PAGE);
    // unimplemented gaps: below ram, above dataflash and below flash
    unimpl = ((g >= lgam_pkg::GLB_REG_END) && (g < RAM_LOW)) ||
             ((g >= DF_HIGH) && (g < lgam_pkg::GLB_DF_END)) ||
             ((g >= lgam_pkg::GLB_DF_END) && (g < FLASH_LOW));
    x.valid = v;
    x.gaddr = g;
    // debug resources only in firmware cycles
    x.debugSel = v && inDebug && fw;
    x.unimpl = v && !inDebug && unimpl;
    x.moduleSel = v && !inDebug && !unimpl;
    x.regSel = v && !inDebug && (g < lgam_pkg::GLB_REG_END);
    return x;
  endfunction : xlatAccess

  assign fwCycle = debugFirmwareRead || debugFirmwareWrite;

  // combinational translation from current page registers
  always_comb begin
    coreXlat_nxt = xlatAccess(coreValid, coreAddr, coreGlobal, fwCycle, debugActive,
                              globalPage_r, progPage_r, ramPage_r, dfPage_r);
    // global page ignored without a global instruction
    // same expansion for the debug unit
    debugXlat_nxt = xlatAccess(debugValid, debugAddr, 1'b0, fwCycle, debugActive,
                               globalPage_r, progPage_r, ramPage_r, dfPage_r);
    // core illegal access; firmware commands are exempt
    // no external bus, so nothing leaves the chip
    illegal_nxt = coreXlat_nxt.unimpl && !coreFirmware;
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      coreXlat_r <= '0;
      debugXlat_r <= '0;
      illegal_r <= 1'b0;
    end else begin
      coreXlat_r <= coreXlat_nxt;
      debugXlat_r <= debugXlat_nxt;
      illegal_r <= illegal_nxt;
    end
  end

  // ---------------------------------------------------------------
  // register bus and page registers
  // ---------------------------------------------------------------
  assign regIdx = avsAddress[7:2];
  // a write lands on the edge where the master sees waitrequest low
  assign busWr = avsWrite && !wait_r && avsByteEnable[0];

  always_comb begin
    globalPage_nxt = globalPage_r;
    progPage_nxt = progPage_r;
    ramPage_nxt = ramPage_r;
    dfPage_nxt = dfPage_r;
    // read data stands until the next read replaces it
    rdata_nxt = rdata_r;
    // one wait state, then a single low cycle per request
    wait_nxt = !((avsRead || avsWrite) && wait_r);
    // page indices writable at any time
    if (busWr) begin
      unique case (regIdx)
        lgam_pkg::IDX_GLOBAL_PAGE: globalPage_nxt = avsWriteData[6:0];
        lgam_pkg::IDX_PROG_PAGE: progPage_nxt = avsWriteData[7:0];
        lgam_pkg::IDX_RAM_PAGE: ramPage_nxt = avsWriteData[7:0];
        lgam_pkg::IDX_DF_PAGE: dfPage_nxt = avsWriteData[7:0];
        default: ;
      endcase
    end
    // far call/return load wins, its sequence cannot be held off
    if (farPageLoad) begin
      progPage_nxt = farPageData;
    end
    if (avsRead && wait_r) begin
      unique case (regIdx)
        lgam_pkg::IDX_GLOBAL_PAGE: rdata_nxt = {25'h0, globalPage_r};
        lgam_pkg::IDX_PROG_PAGE: rdata_nxt = {24'h0, progPage_r};
        lgam_pkg::IDX_RAM_PAGE: rdata_nxt = {24'h0, ramPage_r};
        lgam_pkg::IDX_DF_PAGE: rdata_nxt = {24'h0, dfPage_r};
        lgam_pkg::IDX_STATUS: rdata_nxt = {29'h0, illegal_r, debugActive, modeSpecial_r};
        default: rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      globalPage_r <= lgam_pkg::GLOBAL_PAGE_RST;
      progPage_r <= lgam_pkg::PROG_PAGE_RST;
      ramPage_r <= lgam_pkg::RAM_PAGE_RST;
      dfPage_r <= lgam_pkg::DF_PAGE_RST;
      wait_r <= 1'b1;
      rdata_r <= 32'h0000_0000;
    end else begin
      globalPage_r <= globalPage_nxt;
      progPage_r <= progPage_nxt;
      ramPage_r <= ramPage_nxt;
      dfPage_r <= dfPage_nxt;
      wait_r <= wait_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // ---------------------------------------------------------------
  // operating mode
  // ---------------------------------------------------------------
  // mode pin crosses in from outside; no reset on this chain, so the pin
  // level has already settled through it by the time reset lets go
  always_comb begin
    strapSync_nxt = {strapSync_r[1:0], modeStrap};
    strapLevel_nxt = strapLevel_r;
    // a change counts once the second and third stages agree
    if (strapSync_r[1] == strapSync_r[2]) begin
      strapLevel_nxt = strapSync_r[1];
    end
  end

  always_ff @(posedge clk_sys) begin
    strapSync_r <= strapSync_nxt;
    strapLevel_r <= strapLevel_nxt;
  end

  // strap is caught on the first edge after release, not under reset
  always_comb begin
    strapTaken_nxt = 1'b1;
    modeSpecial_nxt = strapTaken_r ? modeSpecial_r : strapLevel_r;
    // special mode with debugActive high: debug unit drives execution
    inCtrl_nxt = modeSpecial_nxt && debugActive;
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      strapTaken_r <= 1'b0;
      modeSpecial_r <= 1'b0;
      inCtrl_r <= 1'b0;
    end else begin
      strapTaken_r <= strapTaken_nxt;
      modeSpecial_r <= modeSpecial_nxt;
      inCtrl_r <= inCtrl_nxt;
    end
  end

  assign avsReadData = rdata_r;
  assign avsWaitrequest = wait_r;
  assign programWindowPage = progPage_r;
  assign coreXlat = coreXlat_r;
  assign debugXlat = debugXlat_r;
  assign illegalAccessReset = illegal_r;
  assign debugInControl = inCtrl_r;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  sequence ramWinReq;
    coreValid && !coreGlobal && (coreAddr[15:12] == 4'h1);
  endsequence

  sequence pageWrite;
    busWr && (regIdx == lgam_pkg::IDX_RAM_PAGE) && !farPageLoad;
  endsequence

  ram_window_a: assert property (ramWinReq |=>
    coreXlat_r.gaddr == {3'b000, $past(ramPage_r), $past(coreAddr[11:0])})
    else $error("ram window address wrong");

  ram_reset_a: assert property ($rose(resetn) |-> ramPage_r == 8'hFD)
    else $error("ram page reset value wrong");

  fixed_ram_a: assert property (coreValid && !coreGlobal && coreAddr[15:13] == 3'b001 |=>
    coreXlat_r.gaddr[22:12] == {3'b000, 7'h7F, $past(coreAddr[12])})
    else $error("fixed ram page wrong");

  prog_window_a: assert property (coreValid && !coreGlobal && coreAddr[15:14] == 2'b10 |=>
    coreXlat_r.gaddr == {1'b1, $past(progPage_r), $past(coreAddr[13:0])})
    else $error("program window address wrong");

  global_addr_a: assert property (coreValid && coreGlobal |=>
    coreXlat_r.gaddr == {$past(globalPage_r), $past(coreAddr)})
    else $error("global address wrong");

  // page write applies to the next access
  page_update_a: assert property (pageWrite ##1 ramWinReq |=>
    coreXlat_r.gaddr[19:12] == $past(avsWriteData[7:0], 2))
    else $error("page write not applied");

  // debug select needs a firmware cycle
  debug_sel_a: assert property (coreXlat_r.debugSel |->
    $past(fwCycle) && $past(debugActive) && !coreXlat_r.moduleSel)
    else $error("debug select without firmware cycle");

  illegal_rst_a: assert property (coreValid && !coreFirmware && coreXlat_nxt.unimpl |=>
    illegalAccessReset)
    else $error("illegal access not flagged");

  far_load_a: assert property (farPageLoad |=> programWindowPage == $past(farPageData))
    else $error("far page load lost");

  bus_answer_a: assert property ((avsRead || avsWrite) && avsWaitrequest |=> !avsWaitrequest)
    else $error("bus answer late");

  debug_hide_a: assert property (debugActive && coreValid && !coreGlobal &&
    coreAddr[15:8] == 8'hFF |=> !coreXlat_r.moduleSel)
    else $error("debug page not hidden");

  in_control_a: assert property (modeSpecial_r && debugActive |=> debugInControl)
    else $error("debug control not given");

  strap_hold_a: assert property (strapTaken_r |=> $stable(modeSpecial_r))
    else $error("mode changed after latch");

endmodule : lgam_mapper

// ==== hdl/lgam_pkg.sv ====
package lgam_pkg;

  // ---------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [5:0] IDX_GLOBAL_PAGE = 6'h10;
  localparam logic [5:0] IDX_PROG_PAGE = 6'h15;
  localparam logic [5:0] IDX_RAM_PAGE = 6'h16;
  localparam logic [5:0] IDX_DF_PAGE = 6'h17;
  localparam logic [5:0] IDX_STATUS = 6'h18;

  // ---------------------------------------------------------------
  // values after reset
  // ---------------------------------------------------------------
  localparam logic [6:0] GLOBAL_PAGE_RST = 7'h00;
  localparam logic [7:0] PROG_PAGE_RST = 8'hFE;
  localparam logic [7:0] RAM_PAGE_RST = 8'hFD;
  localparam logic [7:0] DF_PAGE_RST = 8'hFE;

  // ---------------------------------------------------------------
  // local windows
  // ---------------------------------------------------------------
  localparam logic [15:0] LOC_DF_WIN = 16'h0800;
  localparam logic [15:0] LOC_DF_FIXED = 16'h0C00;
  localparam logic [15:0] LOC_RAM_WIN = 16'h1000;
  localparam logic [15:0] LOC_RAM_FIXED = 16'h2000;
  localparam logic [15:0] LOC_FLASH_FIXED_LO = 16'h4000;
  localparam logic [15:0] LOC_PROG_WIN = 16'h8000;
  localparam logic [15:0] LOC_UNPAGED = 16'hC000;

  // fixed pages seen through the unpaged windows
  localparam logic [6:0] DF_FIXED_PAGE_HI = 7'h7F;
  localparam logic [6:0] RAM_FIXED_PAGE_HI = 7'h7F;
  localparam logic [7:0] FLASH_LOW_PAGE = 8'hFD;
  localparam logic [7:0] FLASH_TOP_PAGE = 8'hFF;

  // ---------------------------------------------------------------
  // global map
  // ---------------------------------------------------------------
  localparam logic [22:0] GLB_REG_END = 23'h00_0800;
  localparam logic [22:0] GLB_RAM_TOP = 23'h10_0000;
  localparam logic [22:0] GLB_DF_END = 23'h14_0000;
  localparam logic [22:0] GLB_FLASH_BASE = 23'h40_0000;
  localparam logic [14:0] GLB_DEBUG_PAGE = 15'h7FFF;

  // ---------------------------------------------------------------
  // translation result
  // ---------------------------------------------------------------
  typedef struct packed {
    logic valid;
    logic [22:0] gaddr;
    logic moduleSel;
    logic regSel;
    logic debugSel;
    logic unimpl;
  } lgam_xlat_t;

endpackage : lgam_pkg

// ==== testbench/lgam_master_model.sv ====
`timescale 1ns/10ps
module lgam_master_model (
  // clock
  input wire logic clk_sys,
  // processor core side
  output logic coreValid,
  output logic [15:0] coreAddr,
  output logic coreGlobal,
  output logic coreFirmware,
  output logic farPageLoad,
  output logic [7:0] farPageData,
  // debug unit side
  output logic debugValid,
  output logic [15:0] debugAddr
);
  initial begin
    coreValid = 1'b0;
    coreAddr = 16'h0000;
    coreGlobal = 1'b0;
    coreFirmware = 1'b0;
    farPageLoad = 1'b0;
    farPageData = 8'h00;
    debugValid = 1'b0;
    debugAddr = 16'h0000;
  end
  // idle address is inverted so a stale value never passes for a live one
  task automatic coreAccess(input logic [15:0] a, input logic g, input logic f);
    @(posedge clk_sys);
    coreValid <= 1'b1;
    coreAddr <= a;
    coreGlobal <= g;
    coreFirmware <= f;
    @(posedge clk_sys);
    coreValid <= 1'b0;
    coreAddr <= ~a;
    coreGlobal <= 1'b0;
    coreFirmware <= 1'b0;
  endtask : coreAccess
  task automatic debugAccess(input logic [15:0] a);
    @(posedge clk_sys);
    debugValid <= 1'b1;
    debugAddr <= a;
    @(posedge clk_sys);
    debugValid <= 1'b0;
    debugAddr <= ~a;
  endtask : debugAccess
  task automatic farLoad(input logic [7:0] p);
    @(posedge clk_sys);
    farPageLoad <= 1'b1;
    farPageData <= p;
    @(posedge clk_sys);
    farPageLoad <= 1'b0;
    farPageData <= ~p;
  endtask : farLoad
endmodule : lgam_master_model

// ==== testbench/local_global_address_mapper_tb_top.sv ====
`timescale 1ns/10ps
module local_global_address_mapper_tb_top;
  logic clk_sys, resetn, avsRead, avsWrite, avsWaitrequest, coreValid, coreGlobal, coreFirmware;
  logic farPageLoad, illegalAccessReset, debugValid, debugActive, debugFirmwareRead;
  logic debugFirmwareWrite, modeStrap, debugInControl;
  logic [7:0] avsAddress, farPageData, programWindowPage;
  logic [31:0] avsWriteData, avsReadData, rd;
  logic [3:0] avsByteEnable;
  logic [15:0] coreAddr, debugAddr;
  lgam_pkg::lgam_xlat_t coreXlat, debugXlat;
  int failures = 0;
  int checks = 0;
  logic [15:0] tbl [10] = '{16'h1234, 16'h2345, 16'h3FFF, 16'h0800, 16'h0BFF, 16'h8000,
    16'hBFFF, 16'hC000, 16'hFFFF, 16'h4001};
  // ------------------------------
  // clock, reset, instances
  // ------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  // ram smaller than 12KB so the reset page holds a hole
  lgam_mapper #(.RAM_SIZE(32'h0000_2800)) uut (.clk_sys(clk_sys), .resetn(resetn),
    .avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite),
    .avsWriteData(avsWriteData), .avsByteEnable(avsByteEnable), .avsReadData(avsReadData),
    .avsWaitrequest(avsWaitrequest), .coreValid(coreValid), .coreAddr(coreAddr),
    .coreGlobal(coreGlobal), .coreFirmware(coreFirmware), .farPageLoad(farPageLoad),
    .farPageData(farPageData), .programWindowPage(programWindowPage), .coreXlat(coreXlat),
    .illegalAccessReset(illegalAccessReset), .debugValid(debugValid), .debugAddr(debugAddr),
    .debugActive(debugActive), .debugFirmwareRead(debugFirmwareRead),
    .debugFirmwareWrite(debugFirmwareWrite), .debugXlat(debugXlat), .modeStrap(modeStrap),
    .debugInControl(debugInControl));
  lgam_master_model master (.clk_sys(clk_sys), .coreValid(coreValid), .coreAddr(coreAddr),
    .coreGlobal(coreGlobal), .coreFirmware(coreFirmware), .farPageLoad(farPageLoad),
    .farPageData(farPageData), .debugValid(debugValid), .debugAddr(debugAddr));
  // ------------------------------
  // shared tasks
  // ------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic tally_and_finish();
    if (failures == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : tally_and_finish
  // waitrequest is sampled at the rising edge; the request stands until it is seen low
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
    input logic [3:0] be);
    @(posedge clk_sys);
    avsAddress <= a;
    avsWrite <= wr;
    avsRead <= ~wr;
    avsWriteData <= wd;
    avsByteEnable <= be;
    do begin
      @(posedge clk_sys);
    end while (avsWaitrequest !== 1'b0);
    rd = avsReadData;
    avsRead <= 1'b0;
    avsWrite <= 1'b0;
  endtask : bus
  task automatic core(input logic [15:0] a, input logic g, input logic f);
    master.coreAccess(a, g, f);
    #1;
  endtask : core
  function automatic logic [22:0] expAddr(input logic [15:0] a, input logic g,
    input logic [6:0] gp, input logic [7:0] pp, input logic [7:0] rp, input logic [7:0] ep);
    if (g) return {gp, a};
    if (a >= 16'hC000) return {1'b1, 8'hFF, a[13:0]};
    if (a >= 16'h8000) return {1'b1, pp, a[13:0]};
    if (a >= 16'h4000) return {1'b1, 8'hFD, a[13:0]};
    if (a >= 16'h3000) return {3'b000, 8'hFF, a[11:0]};
    if (a >= 16'h2000) return {3'b000, 8'hFE, a[11:0]};
    if (a >= 16'h1000) return {3'b000, rp, a[11:0]};
    if (a >= 16'h0800) return {5'b00100, ep, a[9:0]};
    return {7'h00, a};
  endfunction : expAddr
  // ------------------------------
  // scenarios
  // ------------------------------
  task automatic test_reset();
    bus(1'b0, 8'h58, 32'h0, 4'hF);
    check("ram page rst", rd, 32'h0000_00FD);
    bus(1'b0, 8'h54, 32'h0, 4'hF);
    check("prog page rst", rd, 32'h0000_00FE);
    bus(1'b0, 8'h40, 32'h0, 4'hF);
    check("global page rst", rd, 32'h0);
    bus(1'b0, 8'h7C, 32'h0, 4'hF);
    check("unmapped read", rd, 32'h0);
    bus(1'b1, 8'h58, 32'h0000_0011, 4'hE);
    bus(1'b0, 8'h58, 32'h0, 4'hF);
    check("byteenable ignored", rd, 32'h0000_00FD);
  endtask : test_reset
  task automatic test_windows();
    logic [22:0] e;
    bus(1'b1, 8'h58, 32'h0000_0005, 4'hF);
    bus(1'b1, 8'h5C, 32'h0000_0023, 4'hF);
    bus(1'b1, 8'h54, 32'h0000_0040, 4'hF);
    bus(1'b0, 8'h5C, 32'h0, 4'hF);
    check("df page rw", rd, 32'h0000_0023);
    for (int i = 0; i < 10; i++) begin
      core(tbl[i], 1'b0, 1'b0);
      e = expAddr(tbl[i], 1'b0, 7'h00, 8'h40, 8'h05, 8'h23);
      check("window gaddr", coreXlat.gaddr, e);
    end
    // page zero lands on the registers; the core access rises on the landing edge
    fork
      bus(1'b1, 8'h58, 32'h0000_0000, 4'hF);
      begin
        repeat (2) @(posedge clk_sys);
        core(16'h1010, 1'b0, 1'b0);
      end
    join
    check("ram page 0", coreXlat.gaddr, 23'h00_0010);
    check("ram page 0 regSel", coreXlat.regSel, 1'b1);
  endtask : test_windows
  task automatic test_global();
    logic [22:0] e;
    bus(1'b1, 8'h40, 32'h0000_0014, 4'hF);
    core(16'h5000, 1'b1, 1'b0);
    check("global gaddr", coreXlat.gaddr, 23'h14_5000);
    core(16'h5000, 1'b0, 1'b0);
    e = expAddr(16'h5000, 1'b0, 7'h14, 8'h00, 8'h00, 8'h00);
    check("global ignored", coreXlat.gaddr, e);
  endtask : test_global
  task automatic test_far();
    logic [22:0] e;
    master.farLoad(8'h33);
    #1;
    check("far page", programWindowPage, 8'h33);
    bus(1'b0, 8'h54, 32'h0, 4'hF);
    check("far page read", rd, 32'h0000_0033);
    core(16'h8004, 1'b0, 1'b0);
    e = expAddr(16'h8004, 1'b0, 7'h14, 8'h33, 8'h00, 8'h00);
    check("far page gaddr", coreXlat.gaddr, e);
  endtask : test_far
  task automatic test_debug();
    bus(1'b1, 8'h58, 32'h0000_0007, 4'hF);
    master.debugAccess(16'h1234);
    #1;
    check("debug expand", debugXlat.gaddr, 23'h00_7234);
    @(posedge clk_sys);
    debugActive <= 1'b1;
    debugFirmwareRead <= 1'b1;
    master.debugAccess(16'hFF10);
    #1;
    check("debug sel", {debugXlat.debugSel, debugXlat.moduleSel}, 2'b10);
    check("debug in control", debugInControl, 1'b1);
    core(16'hFF20, 1'b0, 1'b1);
    check("core debug sel", {coreXlat.debugSel, coreXlat.moduleSel}, 2'b10);
    @(posedge clk_sys);
    debugFirmwareRead <= 1'b0;
    master.debugAccess(16'hFF10);
    #1;
    check("debug hidden", {debugXlat.debugSel, debugXlat.moduleSel}, 2'b00);
    bus(1'b1, 8'h54, 32'h0000_00FF, 4'hF);
    debugFirmwareWrite <= 1'b1;
    master.debugAccess(16'hBF00);
    #1;
    check("debug bf00", {debugXlat.debugSel, debugXlat.gaddr}, {1'b1, 23'h7F_FF00});
    @(posedge clk_sys);
    debugFirmwareWrite <= 1'b0;
    debugActive <= 1'b0;
    master.debugAccess(16'hFF10);
    #1;
    check("debug off", {debugXlat.debugSel, debugXlat.moduleSel}, 2'b01);
  endtask : test_debug
  // ram low is 0x10_0000 minus 0x2800, inside reset page 0xFD
  task automatic test_illegal();
    bus(1'b1, 8'h58, 32'h0000_00FD, 4'hF);
    core(16'h1000, 1'b0, 1'b0);
    check("hole unimpl", {coreXlat.unimpl, illegalAccessReset}, 2'b11);
    core(16'h1800, 1'b0, 1'b0);
    check("ram low impl", {coreXlat.unimpl, illegalAccessReset}, 2'b00);
    core(16'h1000, 1'b0, 1'b1);
    check("firmware exempt", {coreXlat.unimpl, illegalAccessReset}, 2'b10);
  endtask : test_illegal
  // reset again in mid-run with each strap level; the page must come back to 0xFD
  task automatic test_mode();
    for (int s = 0; s < 2; s++) begin
      bus(1'b1, 8'h58, 32'h0000_0012, 4'hF);
      @(posedge clk_sys);
      modeStrap <= s[0];
      resetn <= 1'b0;
      debugActive <= 1'b1;
      repeat (5) @(posedge clk_sys);
      resetn <= 1'b1;
      bus(1'b0, 8'h58, 32'h0, 4'hF);
      check("ram page rerst", rd, 32'h0000_00FD);
      bus(1'b0, 8'h60, 32'h0, 4'hF);
      check("mode status", rd, {30'h0, 1'b1, s[0]});
      check("mode in control", debugInControl, s[0]);
    end
    debugActive <= 1'b0;
  endtask : test_mode
  // ------------------------------
  // main sequence and watchdog
  // ------------------------------
  initial begin
    resetn = 1'b0;
    avsAddress = 8'h00;
    avsRead = 1'b0;
    avsWrite = 1'b0;
    avsWriteData = 32'h0;
    avsByteEnable = 4'h0;
    debugActive = 1'b0;
    debugFirmwareRead = 1'b0;
    debugFirmwareWrite = 1'b0;
    modeStrap = 1'b1;
    repeat (5) @(posedge clk_sys);
    resetn <= 1'b1;
    test_reset();
    test_windows();
    test_global();
    test_far();
    test_debug();
    test_illegal();
    test_mode();
    tally_and_finish();
  end
  // the tests take well under a thousand cycles
  initial begin
    repeat (20000) @(posedge clk_sys);
    failures++;
    tally_and_finish();
  end
endmodule : local_global_address_mapper_tb_top
